// >>> bench/ofd_src.sv
// Upstream encoder model offering one frame of coded bits per go pulse
`timescale 1ns/1ps
`default_nettype none
module ofd_src (
  input  wire logic clk_in,
  input  wire logic arst_n_in,
  input  wire logic go_in,
  input  wire logic rnd_in,
  input  wire logic ready_in,
  output logic      bit_out,
  output logic      valid_out
);
  logic [11:0] left_r;
  // Serial bits, each held until taken; the line wanders when idle
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      left_r  <= 12'h000;
      bit_out <= 1'b0;
    end else if (go_in) begin
      left_r <= ofd_pkg::BLK_M_QPSK;
    end else if (!valid_out || ready_in) begin
      left_r  <= valid_out ? left_r - 12'h001 : left_r;
      bit_out <= rnd_in;
    end
  end
  // Stops at the frame end so the bench can count frames exactly
  assign valid_out = (left_r != 12'h000);
endmodule
`default_nettype wire

// >>> bench/tb_ofdm_interleave_map_pilot.sv
// Self-checking bench for the interleave, map and pilot stage
`timescale 1ns/1ps
`default_nettype none
module tb_ofdm_interleave_map_pilot;
  import ofd_pkg::*;
  logic        clk = 0, rst_n = 0, hsel = 0, hwrite = 0, req = 0, sst = 0, go = 0;
  logic        bit_v, bit_d, bit_rdy, hrdy, hresp, c_rdy, c_v, c_pil;
  logic [1:0]  htrans = 0, kind = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, r, rnd = 32'hdced0ec6;
  logic [15:0] c_re, c_im;
  logic [33:0] q[$];
  logic [33:0] e;
  int          miscompares = 0, cmp_count = 0, n;
  logic [31:0] cfg[3] = '{32'h224, 32'h364, 32'h284};
  logic [15:0] mg[3]  = '{16'h16a1, 16'h0b50, 16'h16a1};
  logic [15:0] pl[2]  = '{16'hd555, 16'he000};
  ofd_tx u_dut (.sys_clk_in(clk), .arst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy), .hresp_out(hresp),
    .bit_in(bit_d), .bit_valid_in(bit_v), .bit_ready_out(bit_rdy), .car_req_in(req),
    .car_kind_in(kind), .sym_start_in(sst), .car_ready_out(c_rdy), .car_valid_out(c_v),
    .car_pilot_out(c_pil), .car_re_out(c_re), .car_im_out(c_im));
  ofd_src u_src (.clk_in(clk), .arst_n_in(rst_n), .go_in(go), .rnd_in(rnd[0]),
    .ready_in(bit_rdy), .bit_out(bit_d), .valid_out(bit_v));
  // Clock and random source
  always #2 clk = ~clk;
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  always @(posedge clk) rnd <= lfsr_next(rnd);
  function automatic logic [15:0] mag(input logic [15:0] v);
    return v[15] ? -v : v;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One single AHB-Lite word transfer, zero-wait answers tolerated or not
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
    check(hresp, 0);
  endtask
  // One carrier request; x holds absolute flag, pilot flag, re, im
  task automatic car(input logic [1:0] k, input logic s, input logic [33:0] x);
    @(posedge clk);
    req <= 1;
    kind <= k;
    sst <= s;
    if (x[33:32] != 2'h3) q.push_back(x);
    @(posedge clk);
    req <= 0;
    sst <= 0;
  endtask
  // Monitor: every answer takes the oldest note; data signs are random
  always @(negedge clk) begin
    if (c_v === 1'b1) begin
      check(q.size() != 0, 1);
      e = q.size() ? q.pop_front() : '1;
      check(c_pil, e[32]);
      check(e[33] ? mag(c_re) : c_re, e[31:16]);
      check(e[33] ? mag(c_im) : c_im, e[15:0]);
    end
  end
  initial begin
    #100000;
    miscompares++;
    close_out();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1;
    ahb(0, CTRL_OFS, 0);
    check(r, CTRL_RST);
    ahb(0, STAT_OFS, 0);
    check(r, 0);
    ahb(0, 32'h0c, 0);
    check(r, 0);
    // Data asked for with nothing held: no answer, sticky flag
    car(KIND_DATA, 0, {2'h3, 32'h0});
    repeat (4) @(posedge clk);
    check(q.size(), 0);
    ahb(0, STAT_OFS, 0);
    check(r[STAT_UNDER_BIT], 1);
    ahb(1, STAT_OFS, 32'h0001_0000);
    ahb(0, STAT_OFS, 0);
    check(r[STAT_UNDER_BIT], 0);
    // A ranging subscriber's pilot is one twelfth of full scale
    check(mag(pl[1]) / 12, 32'h2aa);
    // Per-allocation settings: reference, attenuated, upstream asking boost
    for (int i = 0; i < 3; i++) begin
      // Settings latch only from idle, so enable is dropped while draining
      ahb(1, CTRL_OFS, cfg[i]);
      repeat (3) @(posedge clk);
      if (i < 2) car(KIND_PIL, 1, {2'h1, pl[i], 16'h0});
      car(KIND_NULL, 0, {2'h0, 32'h0});
      go <= 1;
      @(posedge clk);
      go <= 0;
      for (int p = 0; p < 96; p++) begin
        n = 0;
        do @(posedge clk); while (c_rdy !== 1'b1 && ++n < 5000);
        check(n < 5000, 1);
        if (p == 0) ahb(1, CTRL_OFS, 0);
        car(KIND_DATA, 0, {2'h2, mg[i], mg[i]});
      end
      repeat (6) @(posedge clk);
      ahb(0, STAT_OFS, 0);
      check(r[15:0], i + 1);
      check(r[STAT_BUSY_BIT], 0);
    end
    close_out();
  end
endmodule
`default_nettype wire

// >>> hw/ofd_pkg.sv
// Constants shared by the interleave, mapping and pilot stage
package ofd_pkg;
  // Register byte offsets
  localparam logic [7:0]  CTRL_OFS        = 8'h00;
  localparam logic [7:0]  STAT_OFS        = 8'h04;
  // Control fields
  localparam int          CTRL_MOD_LSB    = 0;
  localparam int          CTRL_FFT_LSB    = 2;
  localparam int          CTRL_OFDMA_BIT  = 4;
  localparam int          CTRL_DS_BIT     = 5;
  localparam int          CTRL_PWR_LSB    = 6;
  localparam int          CTRL_PONLY_BIT  = 8;
  localparam int          CTRL_EN_BIT     = 9;
  localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
  // Status fields
  localparam int          STAT_UNDER_BIT  = 16;
  localparam int          STAT_BUSY_BIT   = 17;
  // Codes
  localparam logic [1:0]  MOD_QPSK  = 2'h0;
  localparam logic [1:0]  MOD_QAM16 = 2'h1;
  localparam logic [1:0]  MOD_QAM64 = 2'h2;
  localparam logic [1:0]  FFT_64    = 2'h0;
  localparam logic [1:0]  FFT_128   = 2'h1;
  localparam logic [1:0]  FFT_256   = 2'h2;
  localparam logic [1:0]  FFT_512   = 2'h3;
  localparam logic [1:0]  PWR_REF   = 2'h0;
  localparam logic [1:0]  PWR_ATT   = 2'h1;
  localparam logic [1:0]  PWR_BST   = 2'h2;
  localparam logic [1:0]  KIND_NULL = 2'h0;
  localparam logic [1:0]  KIND_DATA = 2'h1;
  localparam logic [1:0]  KIND_PIL  = 2'h2;
  // Bit interleaver block lengths
  localparam logic [11:0] BLK_A_QPSK = 12'h120;
  localparam logic [11:0] BLK_A_Q16  = 12'h240;
  localparam logic [11:0] BLK_A_Q64  = 12'h360;
  localparam logic [11:0] BLK_M_QPSK = 12'h0c0;
  localparam logic [11:0] BLK_M_Q16  = 12'h180;
  localparam logic [11:0] BLK_M_Q64  = 12'h240;
  localparam int          MEM_BITS   = 2304;
  // Generator seeds and default index register taps
  localparam logic [9:0]  IDX_SEED    = 10'h05a;
  localparam logic [9:0]  IDX_TAPS_D  = 10'h240;
  localparam logic [10:0] PIL_SEED_DS = 11'h7ff;
  localparam logic [10:0] PIL_SEED_US = 11'h555;
  // Output scale factors, signed Q2.13
  localparam logic [15:0] SC_REF_QPSK = 16'h16a1;
  localparam logic [15:0] SC_REF_Q16  = 16'h0a1e;
  localparam logic [15:0] SC_REF_Q64  = 16'h04f0;
  localparam logic [15:0] SC_ATT_QPSK = 16'h0b50;
  localparam logic [15:0] SC_ATT_Q16  = 16'h050f;
  localparam logic [15:0] SC_ATT_Q64  = 16'h0278;
  localparam logic [15:0] SC_BST_QPSK = 16'h2d41;
  localparam logic [15:0] SC_BST_Q16  = 16'h143d;
  localparam logic [15:0] SC_BST_Q64  = 16'h09e0;
  localparam logic [15:0] PIL_BOOST   = 16'h2aab;
  localparam logic [15:0] PIL_UNIT    = 16'h2000;
  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_DRAIN} ofd_state_e;
endpackage

// >>> hw/ofd_tx.sv
// Bit interleaver, constellation mapper and pilot generator with AHB-Lite control
//
// Design decisions made here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R1 - Block length is 288/576/864 OFDMA or 192/384/576 OFDM per modulation.
// R2 - At 64 points one 96-symbol block spans two OFDM symbols.
// R3 - At 128 points one 96-symbol block, no carrier permutation after.
// R4 - At 256 points two blocks per symbol, then simple symbol interleaver.
// R5 - At 512 points four blocks per symbol, then simple symbol interleaver.
// R6 - Bits per symbol follow modulation times transform size, 96 up to 2304.
// R7 - Index register is seeded with 0001011010 before every block.
// R8 - Output positions run from 1 to the block length.
// R9 - Each input bit steps the index register; its contents are the candidate.
// R10 - Candidates outside 1..n are dropped and stepping continues.
// R11 - Each bit is written at its accepted index.
// R12 - Mapper takes already interleaved bits one at a time.
// R13 - Reference scaling divides by root 2, 10 or 42.
// R14 - Upstream always uses reference scaling; downstream may attenuate or boost.
// R15 - Attenuated uses root 8, 40, 168; boosted uses the listed gains.
// R16 - Modulation and power are chosen per allocation.
// R17 - Scaled values go onto data carriers in order, one per carrier.
// R18 - Pilots are BPSK with zero imaginary part.
// R19 - Pilot sequence generator uses X^11 + X^2 + 1.
// R20 - Pilot seed is all ones downstream, 10101010101 upstream.
// R21 - First pilot bit on first usable carrier; DC and guards do not step.
// R22 - Pilot real part is 4/3*2*(1/2-w) in data, 2*(1/2-w) pilot-only.
// R23 - A ranging subscriber sends pilots at (1/2-w)/6, imaginary zero; no ranging level here, pilots use PIL_UNIT or PIL_BOOST.
// R24 - Index register feedback taps are a synthesis parameter.
// R25 - Gray bit-to-point assignment is held in a lookup table.
module ofd_tx #(
  parameter logic [9:0] IDX_TAPS = ofd_pkg::IDX_TAPS_D
) (
  input  wire logic        sys_clk_in,
  input  wire logic        arst_n_in,
  input  wire logic        hsel_in,
  input  wire logic [31:0] haddr_in,
  input  wire logic [1:0]  htrans_in,
  input  wire logic        hwrite_in,
  input  wire logic [2:0]  hsize_in,
  input  wire logic [31:0] hwdata_in,
  input  wire logic        hready_in,
  output logic      [31:0] hrdata_out,
  output logic             hreadyout_out,
  output logic             hresp_out,
  input  wire logic        bit_in,
  input  wire logic        bit_valid_in,
  output logic             bit_ready_out,
  input  wire logic        car_req_in,
  input  wire logic [1:0]  car_kind_in,
  input  wire logic        sym_start_in,
  output logic             car_ready_out,
  output logic             car_valid_out,
  output logic             car_pilot_out,
  output logic      [15:0] car_re_out,
  output logic      [15:0] car_im_out
);
  import ofd_pkg::*;

  logic [31:0] ctrl_r, hrdata_r;
  logic        hready_r, aw_r, under_r;
  logic [7:0]  aa_r;
  logic [15:0] frm_cnt_r;
  ofd_state_e  st_r;
  logic [1:0]  mod_r, pwr_r;
  logic        ofdma_r, ds_r, ponly_r;
  logic [11:0] blen_r, tot_r, wcnt_r, wbase_r, rcnt_r, rbase_r, roff_r;
  logic [2:0]  nblk_r, fblk_r, rblk_r, bps_r, rj_r, pcnt_r;
  logic [9:0]  lfsr_r, idx_r;
  logic        idx_ok_r, pend_ok_r;
  logic [5:0]  pend_r;
  logic [10:0] prbs_r;
  logic        mem_r [0:MEM_BITS-1];
  logic        valid_r, pilot_r;
  logic [15:0] re_r, im_r;

  // Block length per modulation and allocation style
  function automatic logic [11:0] blk_len(input logic [1:0] m, input logic a);
    if (m == MOD_QAM64)
      return a ? BLK_A_Q64 : BLK_M_Q64; // [R1]
    else if (m == MOD_QAM16)
      return a ? BLK_A_Q16 : BLK_M_Q16; // [R1]
    else
      return a ? BLK_A_QPSK : BLK_M_QPSK; // [R1]
  endfunction

  // Blocks gathered before draining; OFDMA allocations drain one block at a time
  function automatic logic [2:0] blk_per(input logic [1:0] f, input logic a);
    if (a || f == FFT_64 || f == FFT_128)
      return 3'h1; // [R2] [R3]
    else if (f == FFT_256)
      return 3'h2; // [R4]
    else
      return 3'h4; // [R5]
  endfunction

  // Bits per constellation point
  function automatic logic [2:0] bits_per(input logic [1:0] m);
    if (m == MOD_QAM64)
      return 3'h6;
    else if (m == MOD_QAM16)
      return 3'h4;
    else
      return 3'h2;
  endfunction

  // Index register step, taps set at build time
  function automatic logic [9:0] idx_step(input logic [9:0] v);
    return {v[8:0], ^(v & IDX_TAPS)}; // [R24] [R9]
  endfunction

  // Pilot sequence step, X^11 + X^2 + 1
  function automatic logic [10:0] pil_step(input logic [10:0] v);
    return {v[9:0], v[10] ^ v[1]}; // [R19]
  endfunction

  // Gray-coded axis level lookup, values in odd steps around zero
  function automatic logic [3:0] gray_lvl(input logic [2:0] g, input logic [1:0] m);
    logic [3:0] l;
    l = 4'h0;
    if (m == 2'h1) begin
      l = g[0] ? 4'h1 : 4'hf; // [R25]
    end else if (m == 2'h2) begin
      case (g[1:0]) // [R25]
        2'h0:    l = 4'hd;
        2'h1:    l = 4'hf;
        2'h3:    l = 4'h1;
        default: l = 4'h3;
      endcase
    end else begin
      case (g) // [R25]
        3'h0:    l = 4'h9;
        3'h1:    l = 4'hb;
        3'h3:    l = 4'hd;
        3'h2:    l = 4'hf;
        3'h6:    l = 4'h1;
        3'h7:    l = 4'h3;
        3'h5:    l = 4'h5;
        default: l = 4'h7;
      endcase
    end
    return l;
  endfunction

  // Scale per modulation and power; upstream always at reference
  function automatic logic [15:0] scale(input logic [1:0] m, input logic [1:0] p,
                                        input logic d);
    logic [1:0] pe;
    pe = d ? p : PWR_REF; // [R14]
    if (pe == PWR_ATT)
      return (m == MOD_QAM64) ? SC_ATT_Q64 : (m == MOD_QAM16) ? SC_ATT_Q16 : SC_ATT_QPSK; // [R15]
    else if (pe == PWR_BST)
      return (m == MOD_QAM64) ? SC_BST_Q64 : (m == MOD_QAM16) ? SC_BST_Q16 : SC_BST_QPSK; // [R15]
    else
      return (m == MOD_QAM64) ? SC_REF_Q64 : (m == MOD_QAM16) ? SC_REF_Q16 : SC_REF_QPSK; // [R13]
  endfunction

  // Signed level times scale, kept to 16 bits (largest product fits)
  function automatic logic [15:0] lvl_mul(input logic [3:0] l, input logic [15:0] s);
    logic [19:0] p;
    p = {{16{l[3]}}, l} * {4'h0, s};
    return p[15:0];
  endfunction

  // Bus address phase capture; zero wait states so hready is high from the first clock after reset
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      aw_r     <= 1'b0;
      aa_r     <= 8'h00;
      hready_r <= 1'b0;
    end else begin
      hready_r <= 1'b1;
      if (hready_in) begin
        aw_r <= hsel_in && htrans_in[1] && hwrite_in;
        aa_r <= haddr_in[7:0];
      end
    end
  end

  // Read data is prepared in the address phase; unmapped reads give zero
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_r <= 32'h0000_0000;
    end else if (hready_in && hsel_in && htrans_in[1] && !hwrite_in) begin
      if (haddr_in[7:0] == CTRL_OFS)
        hrdata_r <= ctrl_r;
      else if (haddr_in[7:0] == STAT_OFS)
        hrdata_r <= {14'h0, st_r != ST_IDLE, under_r, frm_cnt_r};
      else
        hrdata_r <= 32'h0000_0000;
    end
  end

  // Control register write in the data phase
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      ctrl_r <= CTRL_RST;
    else if (aw_r && aa_r == CTRL_OFS)
      ctrl_r <= hwdata_in;
  end

  // Underrun flag: a new underrun wins over a write-one clear
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in)
      under_r <= 1'b0;
    else if (car_req_in && car_kind_in == KIND_DATA && !pend_ok_r)
      under_r <= 1'b1;
    else if (aw_r && aa_r == STAT_OFS && hwdata_in[STAT_UNDER_BIT])
      under_r <= 1'b0;
  end

  // Sequencer: per-allocation settings latched at start, then fill, then drain
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st_r    <= ST_IDLE;
      mod_r   <= MOD_QPSK;
      pwr_r   <= PWR_REF;
      ofdma_r <= 1'b0;
      ds_r    <= 1'b0;
      ponly_r <= 1'b0;
      blen_r  <= 12'h000;
      tot_r   <= 12'h000;
      nblk_r  <= 3'h1;
      bps_r   <= 3'h2;
    end else if (st_r == ST_IDLE) begin
      if (ctrl_r[CTRL_EN_BIT]) begin
        st_r    <= ST_FILL;
        mod_r   <= ctrl_r[CTRL_MOD_LSB +: 2]; // [R16]
        pwr_r   <= ctrl_r[CTRL_PWR_LSB +: 2]; // [R16]
        ofdma_r <= ctrl_r[CTRL_OFDMA_BIT];
        ds_r    <= ctrl_r[CTRL_DS_BIT];
        ponly_r <= ctrl_r[CTRL_PONLY_BIT];
        blen_r  <= blk_len(ctrl_r[CTRL_MOD_LSB +: 2], ctrl_r[CTRL_OFDMA_BIT]); // [R1]
        nblk_r  <= blk_per(ctrl_r[CTRL_FFT_LSB +: 2], ctrl_r[CTRL_OFDMA_BIT]);
        bps_r   <= bits_per(ctrl_r[CTRL_MOD_LSB +: 2]);
        // Whole symbol at 256 and 512 points without OFDMA, one block otherwise
        tot_r   <= blk_len(ctrl_r[CTRL_MOD_LSB +: 2], ctrl_r[CTRL_OFDMA_BIT])
                   * {9'h0, blk_per(ctrl_r[CTRL_FFT_LSB +: 2], ctrl_r[CTRL_OFDMA_BIT])}; // [R6]
      end
    end else if (st_r == ST_FILL) begin
      if (idx_ok_r && bit_valid_in && wcnt_r == blen_r - 12'h001 && fblk_r == nblk_r - 3'h1)
        st_r <= ST_DRAIN;
    end else if (!pend_ok_r && rcnt_r == tot_r - 12'h001) begin
      st_r <= ST_IDLE;
    end
  end

  // Index generator and write side of the interleaver memory
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      lfsr_r    <= IDX_SEED;
      idx_r     <= 10'h000;
      idx_ok_r  <= 1'b0;
      wcnt_r    <= 12'h000;
      wbase_r   <= 12'h000;
      fblk_r    <= 3'h0;
      frm_cnt_r <= 16'h0000;
    end else if (st_r == ST_IDLE) begin
      lfsr_r   <= IDX_SEED; // [R7]
      idx_ok_r <= 1'b0;
      wcnt_r   <= 12'h000;
      wbase_r  <= 12'h000;
      fblk_r   <= 3'h0;
    end else if (st_r == ST_FILL) begin
      if (!idx_ok_r) begin
        lfsr_r <= idx_step(lfsr_r); // [R9]
        // Out-of-range candidates are simply skipped
        if (idx_step(lfsr_r) != 10'h000 && {2'h0, idx_step(lfsr_r)} <= blen_r) begin // [R8] [R10]
          idx_r    <= idx_step(lfsr_r);
          idx_ok_r <= 1'b1;
        end
      end else if (bit_valid_in) begin
        idx_ok_r <= 1'b0;
        if (wcnt_r == blen_r - 12'h001) begin
          wcnt_r <= 12'h000;
          lfsr_r <= IDX_SEED; // [R7]
          if (fblk_r == nblk_r - 3'h1) begin
            frm_cnt_r <= frm_cnt_r + 16'h0001;
          end else begin
            fblk_r  <= fblk_r + 3'h1;
            wbase_r <= wbase_r + blen_r; // [R4] [R5]
          end
        end else begin
          wcnt_r <= wcnt_r + 12'h001;
        end
      end
    end
  end

  // Memory write at the accepted index, position 1 stored at offset 0
  always_ff @(posedge sys_clk_in) begin
    if (st_r == ST_FILL && idx_ok_r && bit_valid_in)
      mem_r[wbase_r + {2'h0, idx_r} - 12'h001] <= bit_in; // [R11]
  end

  // Drain: blocks are visited round robin one point at a time, which is the
  // symbol interleave at 256 and 512 points without OFDMA and plain order otherwise
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rcnt_r    <= 12'h000;
      rbase_r   <= 12'h000;
      roff_r    <= 12'h000;
      rblk_r    <= 3'h0;
      rj_r      <= 3'h0;
      pcnt_r    <= 3'h0;
      pend_r    <= 6'h00;
      pend_ok_r <= 1'b0;
    end else if (st_r == ST_IDLE) begin
      rcnt_r  <= 12'h000;
      rbase_r <= 12'h000;
      roff_r  <= 12'h000;
      rblk_r  <= 3'h0;
      rj_r    <= 3'h0;
      if (car_req_in && car_kind_in == KIND_DATA && pend_ok_r)
        pend_ok_r <= 1'b0;
    end else if (pend_ok_r) begin
      // Drain waits while a point is held for the carrier side
      if (car_req_in && car_kind_in == KIND_DATA)
        pend_ok_r <= 1'b0;
    end else if (st_r == ST_DRAIN) begin
      pend_r <= {pend_r[4:0], mem_r[rbase_r + roff_r + {9'h0, rj_r}]}; // [R12]
      rcnt_r <= rcnt_r + 12'h001;
      if (pcnt_r == bps_r - 3'h1) begin
        pcnt_r    <= 3'h0;
        pend_ok_r <= 1'b1;
      end else begin
        pcnt_r <= pcnt_r + 3'h1;
      end
      if (rj_r == bps_r - 3'h1) begin
        rj_r <= 3'h0;
        if (rblk_r == nblk_r - 3'h1) begin
          rblk_r  <= 3'h0;
          rbase_r <= 12'h000;
          roff_r  <= roff_r + {9'h0, bps_r};
        end else begin
          rblk_r  <= rblk_r + 3'h1; // [R4] [R5]
          rbase_r <= rbase_r + blen_r;
        end
      end else begin
        rj_r <= rj_r + 3'h1;
      end
    end
  end

  // Pilot sequence: reseeded by symbol start, stepped on usable carriers only
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      prbs_r <= PIL_SEED_DS;
    end else if (car_req_in && (car_kind_in == KIND_PIL
                 || (car_kind_in == KIND_DATA && pend_ok_r))) begin
      if (sym_start_in)
        prbs_r <= pil_step(ds_r ? PIL_SEED_DS : PIL_SEED_US); // [R20] [R21]
      else
        prbs_r <= pil_step(prbs_r); // [R21]
    end else if (sym_start_in) begin
      prbs_r <= ds_r ? PIL_SEED_DS : PIL_SEED_US; // [R20]
    end
  end

  // Carrier answer: data point, pilot or zero for DC and guard carriers
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      valid_r <= 1'b0;
      pilot_r <= 1'b0;
      re_r    <= 16'h0000;
      im_r    <= 16'h0000;
    end else begin
      valid_r <= 1'b0;
      pilot_r <= 1'b0;
      if (car_req_in && car_kind_in == KIND_PIL) begin
        valid_r <= 1'b1;
        pilot_r <= 1'b1;
        im_r    <= 16'h0000; // [R18]
        // Sequence bit 0 gives the positive level
        if ((sym_start_in ? (ds_r ? PIL_SEED_DS[10] : PIL_SEED_US[10]) : prbs_r[10]))
          re_r <= 16'h0000 - (ponly_r ? PIL_UNIT : PIL_BOOST); // [R22]
        else
          re_r <= ponly_r ? PIL_UNIT : PIL_BOOST; // [R22]
      end else if (car_req_in && car_kind_in == KIND_DATA && pend_ok_r) begin
        valid_r <= 1'b1; // [R17]
        if (mod_r == MOD_QAM64) begin
          re_r <= lvl_mul(gray_lvl(pend_r[5:3], 2'h3), scale(mod_r, pwr_r, ds_r));
          im_r <= lvl_mul(gray_lvl(pend_r[2:0], 2'h3), scale(mod_r, pwr_r, ds_r));
        end else if (mod_r == MOD_QAM16) begin
          re_r <= lvl_mul(gray_lvl({1'b0, pend_r[3:2]}, 2'h2), scale(mod_r, pwr_r, ds_r));
          im_r <= lvl_mul(gray_lvl({1'b0, pend_r[1:0]}, 2'h2), scale(mod_r, pwr_r, ds_r));
        end else begin
          re_r <= lvl_mul(gray_lvl({2'h0, pend_r[1]}, 2'h1), scale(mod_r, pwr_r, ds_r));
          im_r <= lvl_mul(gray_lvl({2'h0, pend_r[0]}, 2'h1), scale(mod_r, pwr_r, ds_r));
        end
      end else if (car_req_in && car_kind_in == KIND_NULL) begin
        valid_r <= 1'b1;
        re_r    <= 16'h0000;
        im_r    <= 16'h0000;
      end
    end
  end

  assign hrdata_out    = hrdata_r;
  assign hreadyout_out = hready_r;
  assign hresp_out     = 1'b0;
  assign bit_ready_out = idx_ok_r;
  assign car_ready_out = pend_ok_r;
  assign car_valid_out = valid_r;
  assign car_pilot_out = pilot_r;
  assign car_re_out    = re_r;
  assign car_im_out    = im_r;

  // Checks
  default clocking dc @(posedge sys_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_take;
    car_req_in && car_kind_in == KIND_DATA && pend_ok_r;
  endsequence
  sequence s_fill_end;
    st_r == ST_FILL ##1 st_r == ST_DRAIN;
  endsequence

  property p_seed;
    st_r == ST_IDLE && ctrl_r[CTRL_EN_BIT] |=> lfsr_r == IDX_SEED && st_r == ST_FILL;
  endproperty
  a_seed: assert property (p_seed) else $error("index seed not loaded"); // [R7]
  property p_idx_rng;
    idx_ok_r |-> idx_r != 10'h000 && {2'h0, idx_r} <= blen_r;
  endproperty
  a_idx_rng: assert property (p_idx_rng) else $error("index out of range"); // [R10]
  property p_step;
    st_r == ST_FILL && !idx_ok_r ##1 st_r == ST_FILL |-> lfsr_r == idx_step($past(lfsr_r));
  endproperty
  a_step: assert property (p_step) else $error("index register did not step"); // [R9]
  property p_accept;
    idx_ok_r && bit_valid_in |=> !idx_ok_r;
  endproperty
  a_accept: assert property (p_accept) else $error("bit accepted twice"); // [R11]
  property p_blen;
    st_r == ST_FILL |-> blen_r == blk_len(mod_r, ofdma_r) && tot_r == blen_r * {9'h0, nblk_r};
  endproperty
  a_blen: assert property (p_blen) else $error("wrong block length"); // [R1]
  property p_frame;
    s_fill_end |-> wbase_r == blen_r * {9'h0, nblk_r - 3'h1} && rcnt_r == 12'h000;
  endproperty
  a_frame: assert property (p_frame) else $error("wrong block count"); // [R5]
  property p_data_out;
    s_take |=> car_valid_out && !car_pilot_out && !pend_ok_r;
  endproperty
  a_data_out: assert property (p_data_out) else $error("data carrier lost"); // [R17]
  property p_pil_im;
    car_valid_out && car_pilot_out |-> car_im_out == 16'h0000;
  endproperty
  a_pil_im: assert property (p_pil_im) else $error("pilot imaginary not zero"); // [R18]
  property p_pil_mag;
    car_valid_out && car_pilot_out && !ponly_r |->
      (car_re_out == PIL_BOOST || car_re_out == 16'h0000 - PIL_BOOST);
  endproperty
  a_pil_mag: assert property (p_pil_mag) else $error("pilot level wrong"); // [R22]
  property p_us_ref;
    s_take and (!ds_r && mod_r == MOD_QPSK) |=> car_re_out == SC_REF_QPSK
      || car_re_out == 16'h0000 - SC_REF_QPSK;
  endproperty
  a_us_ref: assert property (p_us_ref) else $error("upstream not at reference"); // [R14]
  property p_pil_hold;
    car_req_in && car_kind_in == KIND_NULL && !sym_start_in |=> $stable(prbs_r);
  endproperty
  a_pil_hold: assert property (p_pil_hold) else $error("pilot stepped on unused carrier"); // [R21]
endmodule
`default_nettype wire
